// [can_fifo_pkg.sv]
// Package for the CAN FIFO status, pointer and index block.
// Assumes a plain register port with one-cycle read latency.
package can_fifo_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Address is {fifo number, register select, 2'b00}: each FIFO owns four words.
  localparam logic [1:0] REG_SEL_STATUS  = 2'h0;
  localparam logic [1:0] REG_SEL_UADDR   = 2'h1;
  localparam logic [1:0] REG_SEL_INDEX   = 2'h2;
  localparam logic [1:0] REG_SEL_CONTROL = 2'h3;
  localparam int         ADDR_W          = 8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STAT_RX_NOT_EMPTY = 0;
  localparam int STAT_RX_HALF      = 1;
  localparam int STAT_RX_FULL      = 2;
  localparam int STAT_RX_OVERFLOW  = 3;
  localparam int STAT_TX_EMPTY     = 8;
  localparam int STAT_TX_HALF      = 9;
  localparam int STAT_TX_NOT_FULL  = 10;
  localparam int CTRL_DIRECTION    = 7;
  localparam int CTRL_INCREMENT    = 13;
  localparam int CTRL_FIFO_RESET   = 14;
  localparam int CTRL_SIZE_LSB     = 16;
  localparam int INDEX_W           = 5;

  // ---------------------------------------------------------------
  // Reset values and modes
  // ---------------------------------------------------------------
  localparam logic [2:0]  MODE_CONFIGURATION = 3'h4;
  localparam logic [4:0]  SIZE_RESET         = 5'h00;
  localparam logic [31:0] BASE_RESET         = 32'h0000_0000;

  typedef struct packed {
    logic                fifo_direction;
    logic [INDEX_W-1:0]  size_m1;
  } fifo_cfg_t;

  typedef struct packed {
    logic                can_event;
    logic                overflow_event;
  } can_side_t;

endpackage

// [can_fifo_status_pointers.sv]
// Status flags, user address and CAN-side index for sixteen message FIFOs.
// Assumes the CAN engine pulses can_advance_i once per message it sends or stores.
// Assumes software leaves the user address alone while in configuration mode.
//
// How it works
// - TX half flag set while at most half full
// - TX empty flag set when nothing queued
// - RX overflow flag set on overflow event
// - RX full flag set when all slots used
// - RX half flag set when at least half
// - RX not-empty flag set when any message
// - Level flags read-only, follow occupancy live
// - TX user address returns head address
// - RX user address returns tail address
// - User address low two bits read zero
// - TX index names next message to send
// - RX index names next slot to fill
// - Index bits above five read zero
// - Sixteen FIFOs, each independent state
// - Direction bit selects transmit or receive
// - Increment request advances head or tail
// - Configuration mode when mode field is 100
module can_fifo_status_pointers
  import can_fifo_pkg::*;
#(
  parameter int NUM_FIFOS  = 16,
  parameter int MSG_BYTES  = 16,
  parameter int MAX_DEPTH  = 32
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              write_i,
  input  wire logic              read_i,
  output logic [31:0]            rdata_o,
  // Module control
  input  wire logic [2:0]        operating_mode_field_i,
  input  wire logic [31:0]       message_base_i,
  // CAN engine side
  input  wire logic [NUM_FIFOS-1:0] can_advance_i,
  input  wire logic [NUM_FIFOS-1:0] can_overflow_i,
  output logic [NUM_FIFOS-1:0]   fifo_direction_o,
  output logic                   config_mode_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (NUM_FIFOS != 16) begin : g_bad_count
    $error("NUM_FIFOS must be 16 for the four-bit FIFO address field");
  end
  if (MAX_DEPTH != 32 || MSG_BYTES < 4 || (MSG_BYTES % 4) != 0) begin : g_bad_size
    $error("MAX_DEPTH must be 32 and MSG_BYTES a multiple of four");
  end
  // The FIFO number and register select are cut from fixed address bits.
  if (ADDR_W != 8) begin : g_bad_addr
    $error("ADDR_W must be 8 for the fixed register address layout");
  end

  typedef logic [INDEX_W-1:0] idx_t;
  typedef logic [INDEX_W:0]   cnt_t;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Wraps a slot index against the FIFO's own depth.
  function automatic idx_t next_slot(input idx_t cur, input idx_t last);
    next_slot = (cur == last) ? '0 : idx_t'(cur + 1'b1);
  endfunction

  // Number of slots; one bit wider than the index so that a full FIFO of
  // the largest depth still differs from an empty one.
  function automatic cnt_t capacity(input idx_t size_m1);
    capacity = cnt_t'(size_m1) + cnt_t'(1);
  endfunction

  // True when the register port addresses one register of one FIFO.
  function automatic logic hits(input logic [3:0] fifo,
                                input logic [1:0] reg_sel,
                                input int         idx,
                                input logic [1:0] want);
    hits = (fifo == 4'(idx)) && (reg_sel == want);
  endfunction

  // ---------------------------------------------------------------
  // Per-FIFO state
  // ---------------------------------------------------------------
  fifo_cfg_t            cfg       [NUM_FIFOS];
  idx_t                 user_ptr  [NUM_FIFOS];
  idx_t                 can_ptr   [NUM_FIFOS];
  cnt_t                 count     [NUM_FIFOS];
  logic [NUM_FIFOS-1:0] overflow;
  fifo_cfg_t            next_cfg      [NUM_FIFOS];
  idx_t                 next_user_ptr [NUM_FIFOS];
  idx_t                 next_can_ptr  [NUM_FIFOS];
  cnt_t                 next_count    [NUM_FIFOS];
  logic [NUM_FIFOS-1:0] next_overflow;
  logic [31:0]          next_rdata;
  logic                 next_config_mode;
  logic [NUM_FIFOS-1:0] next_direction;

  // ---------------------------------------------------------------
  // Register address decode
  // ---------------------------------------------------------------
  // Each FIFO owns four words, so the FIFO number sits above the select.
  logic [3:0] sel_fifo;
  logic [1:0] sel_reg;
  assign sel_fifo = addr_i[7:4];
  assign sel_reg  = addr_i[3:2];

  // ---------------------------------------------------------------
  // Level flags
  // ---------------------------------------------------------------
  // The flags are worked out from the live count, so no stale level can
  // be latched between two reads.
  // Half flags compare twice the count with the depth, so odd depths need no rounding.
  logic [NUM_FIFOS-1:0] f_tx_half, f_tx_empty, f_tx_nfull, f_rx_full, f_rx_half, f_rx_nempty;
  always_comb begin
    for (int i = 0; i < NUM_FIFOS; i++) begin
      logic dir;
      cnt_t cap;
      dir = cfg[i].fifo_direction;
      cap = capacity(cfg[i].size_m1);
      f_tx_half[i]   = dir & ({count[i], 1'b0} <= {1'b0, cap});
      f_tx_empty[i]  = dir & (count[i] == '0);
      f_tx_nfull[i]  = dir & (count[i] != cap);
      f_rx_full[i]   = ~dir & (count[i] == cap);
      f_rx_half[i]   = ~dir & ({count[i], 1'b0} >= {1'b0, cap});
      f_rx_nempty[i] = ~dir & (count[i] != '0);
    end
  end

  // ---------------------------------------------------------------
  // Configuration and mode
  // ---------------------------------------------------------------
  // Direction and size only move in configuration mode, so a running FIFO
  // never changes its meaning under the engine's feet.
  always_comb begin
    logic cfg_mode;
    logic wr_ctrl;
    cfg_mode = (operating_mode_field_i == MODE_CONFIGURATION);
    wr_ctrl  = 1'b0;
    next_config_mode = cfg_mode;
    for (int i = 0; i < NUM_FIFOS; i++) begin
      next_cfg[i]       = cfg[i];
      next_direction[i] = cfg[i].fifo_direction;
      wr_ctrl = write_i && hits(sel_fifo, sel_reg, i, REG_SEL_CONTROL);
      if (wr_ctrl && cfg_mode) begin
        next_cfg[i].fifo_direction = wdata_i[CTRL_DIRECTION];
        next_cfg[i].size_m1        = wdata_i[CTRL_SIZE_LSB +: INDEX_W];
        next_direction[i]          = wdata_i[CTRL_DIRECTION];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pointers, fill count and overflow
  // ---------------------------------------------------------------
  // An increment and an engine event in one cycle cancel in the count unless one is refused
  // at an empty or full FIFO; each accepted move steps its own pointer.
  always_comb begin
    logic wr_ctrl;
    logic inc;
    logic can_ev;
    wr_ctrl = 1'b0;
    inc     = 1'b0;
    can_ev  = 1'b0;
    for (int i = 0; i < NUM_FIFOS; i++) begin
      next_user_ptr[i] = user_ptr[i];
      next_can_ptr[i]  = can_ptr[i];
      next_count[i]    = count[i];
      next_overflow[i] = overflow[i];
      wr_ctrl = write_i && hits(sel_fifo, sel_reg, i, REG_SEL_CONTROL);
      inc     = wr_ctrl && wdata_i[CTRL_INCREMENT];
      can_ev  = can_advance_i[i];
      if (cfg[i].fifo_direction) begin
        // Software fills at the head, the engine drains at its index.
        if (inc && count[i] != capacity(cfg[i].size_m1)) begin
          next_user_ptr[i] = next_slot(user_ptr[i], cfg[i].size_m1);
          next_count[i] = cnt_t'(next_count[i] + 1'b1);
        end
        if (can_ev && count[i] != '0) begin
          next_can_ptr[i] = next_slot(can_ptr[i], cfg[i].size_m1);
          next_count[i] = cnt_t'(next_count[i] - 1'b1);
        end
      end else begin
        // The engine fills at its index, software drains at the tail.
        if (inc && count[i] != '0) begin
          next_user_ptr[i] = next_slot(user_ptr[i], cfg[i].size_m1);
          next_count[i] = cnt_t'(next_count[i] - 1'b1);
        end
        if (can_ev && count[i] != capacity(cfg[i].size_m1)) begin
          next_can_ptr[i] = next_slot(can_ptr[i], cfg[i].size_m1);
          next_count[i] = cnt_t'(next_count[i] + 1'b1);
        end
      end
      // Writing zero clears; a same-cycle overflow still wins.
      if (write_i && hits(sel_fifo, sel_reg, i, REG_SEL_STATUS)
          && !wdata_i[STAT_RX_OVERFLOW]) begin
        next_overflow[i] = 1'b0;
      end
      if (!cfg[i].fifo_direction && (can_overflow_i[i]
          || (can_ev && count[i] == capacity(cfg[i].size_m1)))) begin
        next_overflow[i] = 1'b1;
      end
      if (wr_ctrl && wdata_i[CTRL_FIFO_RESET]) begin
        next_user_ptr[i] = '0;
        next_can_ptr[i]  = '0;
        next_count[i]    = '0;
        next_overflow[i] = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read data stand for one cycle and are zero otherwise, so a bus that
  // ORs several slaves together needs no extra select logic.
  always_comb begin
    next_rdata = '0;
    if (read_i) begin
      case (sel_reg)
        REG_SEL_STATUS: begin
          next_rdata[STAT_RX_NOT_EMPTY] = f_rx_nempty[sel_fifo];
          next_rdata[STAT_RX_HALF]      = f_rx_half[sel_fifo];
          next_rdata[STAT_RX_FULL]      = f_rx_full[sel_fifo];
          next_rdata[STAT_RX_OVERFLOW]  = overflow[sel_fifo] & ~cfg[sel_fifo].fifo_direction;
          next_rdata[STAT_TX_EMPTY]     = f_tx_empty[sel_fifo];
          next_rdata[STAT_TX_HALF]      = f_tx_half[sel_fifo];
          next_rdata[STAT_TX_NOT_FULL]  = f_tx_nfull[sel_fifo];
        end
        REG_SEL_UADDR: begin
          // Value is undefined in configuration mode; software must not rely on it.
          next_rdata = message_base_i
                     + 32'(sel_fifo) * 32'(MAX_DEPTH * MSG_BYTES)
                     + 32'(user_ptr[sel_fifo]) * 32'(MSG_BYTES);
          next_rdata[1:0] = 2'b00;
        end
        REG_SEL_INDEX: begin
          next_rdata[INDEX_W-1:0] = can_ptr[sel_fifo];
        end
        REG_SEL_CONTROL: begin
          next_rdata[CTRL_DIRECTION] = cfg[sel_fifo].fifo_direction;
          next_rdata[CTRL_SIZE_LSB +: INDEX_W] = cfg[sel_fifo].size_m1;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Configuration group: every FIFO leaves reset as a one-slot receiver.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_FIFOS; i++) begin
        cfg[i] <= '{fifo_direction: 1'b0, size_m1: SIZE_RESET};
      end
      config_mode_o    <= 1'b0;
      fifo_direction_o <= '0;
    end else begin
      for (int i = 0; i < NUM_FIFOS; i++) begin
        cfg[i] <= next_cfg[i];
      end
      config_mode_o    <= next_config_mode;
      fifo_direction_o <= next_direction;
    end
  end

  // Pointers and counts reset to the first slot of an empty FIFO.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_FIFOS; i++) begin
        user_ptr[i] <= '0;
        can_ptr[i]  <= '0;
        count[i]    <= '0;
      end
      overflow <= '0;
    end else begin
      for (int i = 0; i < NUM_FIFOS; i++) begin
        user_ptr[i] <= next_user_ptr[i];
        can_ptr[i]  <= next_can_ptr[i];
        count[i]    <= next_count[i];
      end
      overflow <= next_overflow;
    end
  end

  // Read data clear themselves one cycle after the read strobe.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule

// [can_fifo_status_pointers_asserts.sv]
// Assertions on the register port and mode outputs of the FIFO status block.
// Assumes it is bound to the top module and sees only its ports.
module can_fifo_status_pointers_checker
  import can_fifo_pkg::*;
#(
  parameter int NUM_FIFOS = 16
) (
  // Clock, reset and register port
  input wire logic                 clk_i,
  input wire logic                 rstn_i,
  input wire logic [ADDR_W-1:0]    addr_i,
  input wire logic                 read_i,
  input wire logic [31:0]          rdata_o,
  // Mode and direction
  input wire logic [2:0]           operating_mode_field_i,
  input wire logic [NUM_FIFOS-1:0] fifo_direction_o,
  input wire logic                 config_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic st_rd;
  logic tx_rd;
  assign st_rd = read_i && addr_i[3:2] == REG_SEL_STATUS;
  assign tx_rd = fifo_direction_o[addr_i[7:4]];
  a_index_upper_zero: assert property (read_i && addr_i[3:2] == REG_SEL_INDEX |=> rdata_o[31:5] == '0)
    else $error("index upper bits not zero");
  a_uaddr_aligned: assert property (read_i && addr_i[3:2] == REG_SEL_UADDR |=> rdata_o[1:0] == 2'h0)
    else $error("user address not aligned");
  a_tx_rx_quiet: assert property (st_rd && tx_rd |=> rdata_o[3:0] == 4'h0)
    else $error("receive flags set in transmit");
  a_rx_tx_quiet: assert property (st_rd && !tx_rd |=> rdata_o[10:8] == 3'h0)
    else $error("transmit flags set in receive");
  a_rx_full_half: assert property (st_rd && !tx_rd |=> !rdata_o[2] || rdata_o[1:0] == 2'h3)
    else $error("full without half and not empty");
  a_tx_empty_half: assert property (st_rd && tx_rd |=> !rdata_o[8] || rdata_o[10:9] == 2'h3)
    else $error("empty without half and not full");
  a_stat_reserved_zero: assert property (st_rd |=> rdata_o[31:11] == '0 && rdata_o[7:4] == 4'h0)
    else $error("reserved status bits set");
  a_config_mode_follow: assert property (1'b1 |=> config_mode_o == ($past(operating_mode_field_i) == MODE_CONFIGURATION))
    else $error("configuration mode output wrong");
  a_dir_config_only: assert property ($changed(fifo_direction_o) |-> $past(operating_mode_field_i) == MODE_CONFIGURATION)
    else $error("direction changed outside configuration");
endmodule

bind can_fifo_status_pointers can_fifo_status_pointers_checker #(.NUM_FIFOS(NUM_FIFOS)) checker_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .read_i(read_i), .rdata_o(rdata_o),
  .operating_mode_field_i(operating_mode_field_i), .fifo_direction_o(fifo_direction_o),
  .config_mode_o(config_mode_o));

// [can_engine_model.sv]
// Behavioural CAN engine that stores, sends or overflows one message on command.
// Assumes the bench calls pulse for one FIFO at a time, outside reset.
module can_engine_model #(
  parameter int NUM_FIFOS = 16
) (
  // Clock
  input  wire logic            clk_i,
  // Per-FIFO event pulses
  output logic [NUM_FIFOS-1:0] can_advance_o,
  output logic [NUM_FIFOS-1:0] can_overflow_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    can_advance_o  = '0;
    can_overflow_o = '0;
  end
  // An overflow event carries no store, so the level flags must not move with it.
  task automatic pulse(input int f, input logic over);
    @(posedge clk_i);
    if (over) can_overflow_o <= NUM_FIFOS'(1) << f;
    else can_advance_o <= NUM_FIFOS'(1) << f;
    @(posedge clk_i);
    can_advance_o  <= '0;
    can_overflow_o <= '0;
  endtask
endmodule

// [can_fifo_status_pointers_tb.sv]
// Self-checking bench for the CAN FIFO status, pointer and index block.
// Assumes the engine model drives the CAN side and the bench the register port.
module can_fifo_status_pointers_tb;
  import can_fifo_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] BASE = 32'h0000_1000;
  typedef struct {int f; logic dir; int d; int n; logic [31:0] st;} row_t;
  logic              clk_i   = 1'b0;
  logic              rstn_i  = 1'b0;
  logic [ADDR_W-1:0] addr_i  = '0;
  logic [31:0]       wdata_i = '0;
  logic              write_i = 1'b0;
  logic              read_i  = 1'b0;
  logic [2:0]        mode    = 3'h0;
  logic [31:0]       rdata_o;
  logic [15:0]       adv, ovf, fifo_direction_o;
  logic              config_mode_o;
  int                n_errors = 0;
  int                n_checks = 0;
  int                p;
  row_t              r;
  // The status column is the flag set that a FIFO of depth d shows with n messages in it.
  row_t rows[10] = '{'{0, 1'b1, 4, 0, 32'h700}, '{1, 1'b1, 4, 2, 32'h600},
    '{2, 1'b1, 4, 3, 32'h400}, '{3, 1'b1, 4, 4, 32'h000}, '{15, 1'b1, 16, 9, 32'h400},
    '{4, 1'b0, 4, 1, 32'h001}, '{5, 1'b0, 4, 2, 32'h003}, '{6, 1'b0, 4, 4, 32'h007},
    '{7, 1'b0, 3, 1, 32'h001}, '{8, 1'b0, 1, 1, 32'h007}};
  always #2.5 clk_i = ~clk_i;
  can_fifo_status_pointers can_fifo_status_pointers_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
    .rdata_o(rdata_o), .operating_mode_field_i(mode), .message_base_i(BASE),
    .can_advance_i(adv), .can_overflow_i(ovf), .fifo_direction_o(fifo_direction_o),
    .config_mode_o(config_mode_o));
  can_engine_model can_engine_model_i (.clk_i(clk_i), .can_advance_o(adv), .can_overflow_o(ovf));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input int f, input logic [1:0] s, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= {f[3:0], s, 2'h0};
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rc(input int f, input logic [1:0] s, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= {f[3:0], s, 2'h0};
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 chk(what, exp, rdata_o);
  endtask
  task automatic setmode(input logic [2:0] m);
    @(posedge clk_i);
    mode <= m;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc(0, REG_SEL_STATUS, 32'h0, "status at reset");
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      p = r.n % r.d;
      setmode(MODE_CONFIGURATION);
      chk("config mode on", 32'h1, 32'(config_mode_o));
      wr(r.f, REG_SEL_CONTROL, 32'(r.dir) << CTRL_DIRECTION | 32'(r.d - 1) << CTRL_SIZE_LSB);
      setmode(3'h0);
      chk("config mode off", 32'h0, 32'(config_mode_o));
      repeat (r.n) if (r.dir) wr(r.f, REG_SEL_CONTROL, 32'h1 << CTRL_INCREMENT);
      else can_engine_model_i.pulse(r.f, 1'b0);
      rc(r.f, REG_SEL_STATUS, r.st, "status");
      rc(r.f, REG_SEL_UADDR, BASE + 32'(r.f * 512 + (r.dir ? p * 16 : 0)), "user address");
      rc(r.f, REG_SEL_INDEX, r.dir ? 32'h0 : 32'(p), "index");
      chk("direction", 32'(r.dir), 32'(fifo_direction_o[r.f]));
      $display("row %0d done", i);
    end
    can_engine_model_i.pulse(6, 1'b1);
    rc(6, REG_SEL_STATUS, 32'h00f, "overflow set");
    wr(6, REG_SEL_STATUS, 32'h008);
    rc(6, REG_SEL_STATUS, 32'h00f, "overflow kept");
    wr(6, REG_SEL_STATUS, 32'h000);
    rc(6, REG_SEL_STATUS, 32'h007, "overflow cleared");
    can_engine_model_i.pulse(6, 1'b1);
    wr(6, REG_SEL_CONTROL, 32'h1 << CTRL_INCREMENT | 32'h1 << CTRL_DIRECTION);
    rc(6, REG_SEL_UADDR, BASE + 32'h0000_0c10, "tail");
    rc(6, REG_SEL_STATUS, 32'h00b, "status after read");
    chk("direction kept", 32'h0, 32'(fifo_direction_o[6]));
    rc(15, REG_SEL_CONTROL, 32'h000f_0080, "control readback");
    can_engine_model_i.pulse(3, 1'b1);
    rc(3, REG_SEL_STATUS, 32'h000, "other fifo kept");
    can_engine_model_i.pulse(1, 1'b0);
    rc(1, REG_SEL_INDEX, 32'h1, "tx index");
    rc(1, REG_SEL_STATUS, 32'h600, "tx one left");
    wr(6, REG_SEL_CONTROL, 32'h1 << CTRL_FIFO_RESET);
    wr(4, REG_SEL_CONTROL, 32'h1 << CTRL_FIFO_RESET);
    rc(6, REG_SEL_STATUS, 32'h000, "fifo reset status");
    rc(6, REG_SEL_UADDR, BASE + 32'h0000_0c00, "fifo reset tail");
    rc(4, REG_SEL_INDEX, 32'h0, "fifo reset index");
    $display("overflow, increment and fifo reset done");
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk("direction after reset", 32'h0, 32'(fifo_direction_o));
    rc(1, REG_SEL_STATUS, 32'h000, "status after reset");
    $display("second reset done");
    give_verdict();
  end
endmodule
